// [asc_map.vh]
// constants for the speed change overlap-add engine
// assumes one 10 MHz sample-processing clock, 16-bit mono samples
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_SW 16
`define ASC_AW 10
`define ASC_PW 11
`define ASC_DEPTH 11'h400
`define ASC_MINWL 8'h20
`define ASC_MAXWL 8'ha0
`define ASC_SHORTWL 8'h1f
`define ASC_UNITY 10'h100
`define ASC_HALF 10'h080
`define ASC_ADVMAX 10'h200
`define ASC_DIVN 6'h20
`define ASC_FIFO_D 4
`define ASC_FIFO_AW 2
`endif

// [asc_speed_change.v]
// overlap-add replay speed changer for one audio channel, with output fifo
// assumes source samples arrive on a valid/ready stream in the core clock
`include "asc_map.vh"
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////
// small output fifo, width and depth set by parameters
module asc_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  // honest full and empty
  assign in_ready_o = (cnt_reg != D[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rp_reg];

  // storage, no reset needed
  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  // pointers and fill count
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// speed change engine top
module asc_speed_change (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [`ASC_SW-1:0] source_samples_i,
  input wire source_valid_i,
  output wire source_ready_o,
  input wire [9:0] replay_rate_factor_i,
  output wire [`ASC_SW-1:0] out_sample_o,
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [7:0] wave_len_o
);
  localparam S_FILL = 3'd0;
  localparam S_SRCH = 3'd1;
  localparam S_PICK = 3'd2;
  localparam S_DIV = 3'd3;
  localparam S_WAIT = 3'd4;
  localparam S_GEN = 3'd5;
  localparam S_EMIT = 3'd6;

  reg [`ASC_SW-1:0] mem [0:`ASC_DEPTH-1];
  reg [`ASC_PW-1:0] wr_ptr_reg;
  reg [`ASC_PW-1:0] frame_start_ptr_reg;
  reg [2:0] st_reg;
  reg [7:0] wl_reg;
  reg [7:0] n_reg;
  reg [41:0] acc_reg;
  reg signed [39:0] corr_reg;
  reg [7:0] best_wl_reg;
  reg [41:0] best_acc_reg;
  reg signed [39:0] best_corr_reg;
  reg [9:0] adv_reg;
  reg [9:0] tot_reg;
  reg [9:0] step_reg;
  reg [9:0] k_reg;
  reg [`ASC_SW-1:0] samp_reg;
  reg [31:0] div_num_reg;
  reg [31:0] div_q_reg;
  reg [16:0] div_rem_reg;
  reg [15:0] div_den_reg;
  reg [5:0] div_cnt_reg;
  reg div_adv_reg;
  reg div_neg_reg;
  wire fifo_in_ready;

  // buffer address relative to a base pointer
  function [`ASC_AW-1:0] bidx;
    input [`ASC_PW-1:0] base;
    input [9:0] off;
    begin
      bidx = base[`ASC_AW-1:0] + off;
    end
  endfunction

  wire [`ASC_PW-1:0] fill = wr_ptr_reg - frame_start_ptr_reg;
  wire [9:0] rate = (replay_rate_factor_i < `ASC_HALF) ? `ASC_HALF : replay_rate_factor_i;
  wire compress = (rate > `ASC_UNITY);
  wire [`ASC_PW-1:0] two_max = {2'b00, `ASC_MAXWL, 1'b0};

  assign source_ready_o = (fill != `ASC_DEPTH);
  always @(posedge core_clk_i) begin
    if (source_valid_i & source_ready_o) begin
      mem[wr_ptr_reg[`ASC_AW-1:0]] <= source_samples_i;
    end
  end
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= {`ASC_PW{1'b0}};
    end else if (source_valid_i & source_ready_o) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // A at pointer, B right after
  wire signed [15:0] xa = mem[bidx(frame_start_ptr_reg, {2'b00, n_reg})];
  wire signed [15:0] yb = mem[bidx(frame_start_ptr_reg, {2'b00, n_reg} + {2'b00, wl_reg})];
  wire signed [16:0] dif = {xa[15], xa} - {yb[15], yb};
  wire signed [33:0] sq = dif * dif;
  wire signed [31:0] xy = xa * yb;
  wire [41:0] acc_new = acc_reg + {8'h00, sq[33:0]};
  wire signed [39:0] corr_new = corr_reg + {{8{xy[31]}}, xy};
  wire better = (best_wl_reg == 8'h00) ||
    ({8'h00, acc_new} * {42'd0, best_wl_reg} < {8'h00, best_acc_reg} * {42'd0, wl_reg});
  wire [7:0] wl_sel = best_corr_reg[39] ? `ASC_SHORTWL : best_wl_reg;

  // overlap sample selection for output index k
  wire [9:0] wl10 = {2'b00, wl_reg};
  wire [9:0] m_exp = k_reg - wl10;
  wire in_c = compress ? (k_reg < wl10) : ((k_reg >= wl10) && (m_exp < wl10));
  wire [9:0] m = compress ? k_reg : m_exp;
  wire signed [15:0] ca = mem[bidx(frame_start_ptr_reg, m)];
  wire signed [15:0] cb = mem[bidx(frame_start_ptr_reg, m + wl10)];
  wire [8:0] wa = compress ? {1'b0, wl_reg} - m[8:0] : m[8:0];
  wire [8:0] wb = compress ? m[8:0] : {1'b0, wl_reg} - m[8:0];
  wire signed [25:0] c_num = ca * $signed({1'b0, wa}) + cb * $signed({1'b0, wb});
  wire [25:0] c_mag = c_num[25] ? -c_num : c_num;
  // original after B, plain A, repeat of B
  wire [9:0] raw_off = compress ? k_reg + wl10 : (k_reg < wl10 ? k_reg : m_exp);
  wire [15:0] raw = mem[bidx(frame_start_ptr_reg, raw_off)];

  // divider step, restoring
  wire [17:0] dtry = {div_rem_reg, div_num_reg[31]};
  wire dbit = (dtry >= {2'b00, div_den_reg});
  wire [17:0] dsub = dtry - {2'b00, div_den_reg};
  wire [31:0] q_new = {div_q_reg[30:0], dbit};
  wire [9:0] adv_q = (q_new == 32'h0000_0000) ? 10'h001 :
    (q_new > {22'd0, `ASC_ADVMAX}) ? `ASC_ADVMAX : q_new[9:0];

  ////////////////////////////////////////////////////////////////////////
  // main sequence: search, advance, generate, emit
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= S_FILL;
      frame_start_ptr_reg <= {`ASC_PW{1'b0}};
      wl_reg <= `ASC_MINWL;
      n_reg <= 8'h00;
      acc_reg <= 42'd0;
      corr_reg <= 40'sd0;
      best_wl_reg <= 8'h00;
      best_acc_reg <= 42'd0;
      best_corr_reg <= 40'sd0;
      adv_reg <= 10'h000;
      tot_reg <= 10'h000;
      step_reg <= 10'h000;
      k_reg <= 10'h000;
      samp_reg <= 16'h0000;
      div_num_reg <= 32'h0000_0000;
      div_q_reg <= 32'h0000_0000;
      div_rem_reg <= 17'h0_0000;
      div_den_reg <= 16'h0001;
      div_cnt_reg <= 6'h00;
      div_adv_reg <= 1'b0;
      div_neg_reg <= 1'b0;
      wave_len_o <= 8'h00;
    end else begin
      case (st_reg)
        S_FILL: begin
          if (rate == `ASC_UNITY) begin
            // unity rate passes samples straight through
            if (fill != {`ASC_PW{1'b0}}) begin
              samp_reg <= mem[frame_start_ptr_reg[`ASC_AW-1:0]];
              tot_reg <= 10'h001;
              step_reg <= 10'h001;
              k_reg <= 10'h000;
              st_reg <= S_EMIT;
            end
          end else if (fill >= two_max) begin
            wl_reg <= `ASC_MINWL;
            n_reg <= 8'h00;
            acc_reg <= 42'd0;
            corr_reg <= 40'sd0;
            best_wl_reg <= 8'h00;
            st_reg <= S_SRCH;
          end
        end
        S_SRCH: begin
          if (n_reg == wl_reg - 1'b1) begin
            if (better) begin
              best_wl_reg <= wl_reg;
              best_acc_reg <= acc_new;
              best_corr_reg <= corr_new;
            end
            n_reg <= 8'h00;
            acc_reg <= 42'd0;
            corr_reg <= 40'sd0;
            if (wl_reg == `ASC_MAXWL) begin
              st_reg <= S_PICK;
            end else begin
              wl_reg <= wl_reg + 1'b1;
            end
          end else begin
            n_reg <= n_reg + 1'b1;
            acc_reg <= acc_new;
            corr_reg <= corr_new;
          end
        end
        S_PICK: begin
          wl_reg <= wl_sel;
          wave_len_o <= wl_sel;
          // factor is Q2.8, so compression scales length by 256, not 1024
          div_num_reg <= compress ? {16'd0, wl_sel, 8'h00} : {14'd0, wl_sel} * {22'd0, rate};
          div_den_reg <= compress ? {6'd0, rate - `ASC_UNITY} : {6'd0, `ASC_UNITY - rate};
          div_q_reg <= 32'h0000_0000;
          div_rem_reg <= 17'h0_0000;
          div_cnt_reg <= 6'h00;
          div_adv_reg <= 1'b1;
          st_reg <= S_DIV;
        end
        S_DIV: begin
          div_num_reg <= {div_num_reg[30:0], 1'b0};
          div_rem_reg <= dbit ? dsub[16:0] : dtry[16:0];
          div_q_reg <= q_new;
          div_cnt_reg <= div_cnt_reg + 1'b1;
          if (div_cnt_reg == `ASC_DIVN - 1'b1) begin
            if (div_adv_reg) begin
              adv_reg <= adv_q;
              tot_reg <= compress ? adv_q : adv_q + wl10;
              // pointer moves by the advance, plus one length when compressing
              step_reg <= compress ? adv_q + wl10 : adv_q;
              k_reg <= 10'h000;
              st_reg <= S_WAIT;
            end else begin
              samp_reg <= div_neg_reg ? 16'h0000 - q_new[15:0] : q_new[15:0];
              st_reg <= S_EMIT;
            end
          end
        end
        S_WAIT: begin
          if (fill >= two_max + {1'b0, adv_reg}) begin
            st_reg <= S_GEN;
          end
        end
        S_GEN: begin
          if (in_c) begin
            // weighted sum divided by length
            div_num_reg <= {6'd0, c_mag};
            div_neg_reg <= c_num[25];
            div_den_reg <= {8'h00, wl_reg};
            div_q_reg <= 32'h0000_0000;
            div_rem_reg <= 17'h0_0000;
            div_cnt_reg <= 6'h00;
            div_adv_reg <= 1'b0;
            st_reg <= S_DIV;
          end else begin
            samp_reg <= raw;
            st_reg <= S_EMIT;
          end
        end
        S_EMIT: begin
          if (fifo_in_ready) begin
            k_reg <= k_reg + 1'b1;
            if (k_reg + 1'b1 == tot_reg) begin
              frame_start_ptr_reg <= frame_start_ptr_reg + {1'b0, step_reg};
              st_reg <= S_FILL;
            end else begin
              st_reg <= S_GEN;
            end
          end
        end
        default: begin
          st_reg <= S_FILL;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output fifo, its ready stalls the emit state
  asc_fifo #(
    .W(`ASC_SW),
    .D(`ASC_FIFO_D),
    .AW(`ASC_FIFO_AW)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(samp_reg),
    .in_valid_i(st_reg == S_EMIT),
    .in_ready_o(fifo_in_ready),
    .out_data_o(out_sample_o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i)
  );
endmodule
`default_nettype wire

// [asc_fifo_note_unused.v]
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [asc_chk_sva.sv]
// port checker for the speed change engine
// assumes it is bound onto asc_speed_change, one clock domain
`timescale 1ns/1ns
`default_nettype none
module asc_chk (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] source_samples_i,
  input wire logic source_valid_i,
  input wire logic source_ready_o,
  input wire logic [9:0] replay_rate_factor_i,
  input wire logic [15:0] out_sample_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [7:0] wave_len_o
);
  logic [10:0] take_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////
  // samples taken since reset, saturating
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      take_reg <= 11'h000;
    end else if (source_valid_i && source_ready_o && take_reg != 11'h7ff) begin
      take_reg <= take_reg + 11'h001;
    end
  end
  sequence s_stall;
    out_valid_o && !out_ready_i;
  endsequence
  sequence s_proc;
    replay_rate_factor_i != 10'h100;
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_OUT_HOLD: assert property (s_stall |=> out_valid_o)
    else $error("output valid dropped while stalled");
  AST_OUT_DATA: assert property (s_stall |=> $stable(out_sample_o))
    else $error("output sample changed while stalled");
  AST_NO_DROP: assert property ($fell(out_valid_o) |-> $past(out_ready_i))
    else $error("output vanished without a pop");
  AST_LEN_RANGE: assert property (wave_len_o == 8'h00 || wave_len_o == 8'h1f ||
    (wave_len_o >= 8'h20 && wave_len_o <= 8'ha0))
    else $error("waveform length out of range");
  AST_LEN_SET: assert property ($changed(wave_len_o) |-> wave_len_o != 8'h00)
    else $error("waveform length cleared outside reset");
  AST_EARLY: assert property ((s_proc ##0 take_reg < 11'h140) |-> !out_valid_o)
    else $error("output before enough samples buffered");
  AST_IN_READY: assert property (take_reg < 11'h3ff |-> source_ready_o)
    else $error("input refused with buffer not full");
  AST_FIRST_LEN: assert property ((s_proc ##0 $rose(out_valid_o)) |-> wave_len_o >= 8'h1f)
    else $error("output without a selected length");
endmodule
bind asc_speed_change asc_chk u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .source_samples_i(source_samples_i), .source_valid_i(source_valid_i),
  .source_ready_o(source_ready_o), .replay_rate_factor_i(replay_rate_factor_i),
  .out_sample_o(out_sample_o), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .wave_len_o(wave_len_o)
);
`default_nettype wire

// [asc_src_model.sv]
// audio source model: mono samples repeating a 64-sample table
// assumes the engine takes a sample on valid and ready at a rising edge
`timescale 1ns/1ns
`default_nettype none
module asc_src_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ready_i,
  input wire logic slow_i,
  input wire logic [15:0] wave_i [64],
  output logic [15:0] sample_o,
  output logic valid_o
);
  logic [5:0] idx_reg;
  logic [5:0] nxt;
  initial begin
    sample_o = 16'h0000;
    valid_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // one channel only
  // holds while refused, gaps show inverted data when slow
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      idx_reg <= 6'h00;
      valid_o <= 1'b0;
      sample_o <= ~sample_o;
    end else if (!(valid_o && !ready_i)) begin
      nxt = idx_reg + {5'h00, valid_o};
      idx_reg <= nxt;
      if (slow_i && valid_o) begin
        valid_o <= 1'b0;
        sample_o <= ~sample_o;
      end else begin
        valid_o <= 1'b1;
        sample_o <= wave_i[nxt];
      end
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the speed change engine
// assumes a periodic 64-sample tone, so every mode replays it in phase
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic slow = 1'b0;
  logic [9:0] factor = 10'h200;
  logic [15:0] wave [64];
  logic [15:0] src_data;
  logic [15:0] out_sample;
  logic src_valid;
  logic src_ready;
  logic out_valid;
  logic [7:0] wave_len;
  logic [31:0] rnd = 32'h0000_bd41;
  logic [9:0] fac [5] = '{10'h200, 10'h180, 10'h100, 10'h0c0, 10'h040};
  int num_errors = 0;
  int num_checks = 0;
  logic timed_out = 1'b0;
  initial forever #50 core_clk_i = ~core_clk_i;
  asc_src_model u_src (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .ready_i(src_ready), .slow_i(slow), .wave_i(wave),
    .sample_o(src_data), .valid_o(src_valid));
  asc_speed_change u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .source_samples_i(src_data), .source_valid_i(src_valid),
    .source_ready_o(src_ready), .replay_rate_factor_i(factor),
    .out_sample_o(out_sample), .out_valid_o(out_valid),
    .out_ready_i(out_ready_i), .wave_len_o(wave_len));
  ////////////////////////////////////////////////////////////////////
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // expected output: the tone continues without a phase jump
  function automatic logic [15:0] exp_at(input int k);
    return wave[k % 64];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // one mode: reset, then 40 popped samples under random stalls
  task automatic run_mode(input logic [9:0] f, input logic sl);
    int k;
    int n;
    k = 0;
    n = 0;
    factor = f;
    slow = sl;
    reset_n_i = 1'b0;
    out_ready_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    chk({15'h0000, src_ready}, 16'h0001);
    chk({15'h0000, out_valid}, 16'h0000);
    chk({8'h00, wave_len}, 16'h0000);
    reset_n_i = 1'b1;
    while (k < 40 && n < 30000) begin
      @(negedge core_clk_i);
      if (out_valid === 1'b1 && out_ready_i) begin
        chk(out_sample, exp_at(k));
        k++;
      end
      @(posedge core_clk_i);
      #1;
      rnd = xs(rnd);
      // long stall at the fifth sample fills the fifo
      out_ready_i = (rnd[1:0] != 2'b00) && (k != 4 || n[6:5] == 2'b11);
      n++;
    end
    // a used-up wait counts as a mismatch and skips the remaining modes
    if (k < 40) begin
      num_errors++;
      timed_out = 1'b1;
    end else if (f != 10'h100) begin
      chk({8'h00, wave_len}, 16'h0040);
    end
  endtask
  initial begin
    for (int i = 0; i < 64; i++) begin
      rnd = xs(rnd);
      wave[i] = {{4{rnd[11]}}, rnd[11:0]};
    end
    for (int m = 0; m < 5 && !timed_out; m++) run_mode(fac[m], m[0]);
    results;
  end
endmodule
`default_nettype wire
